// [dv/code_capture.sv]
`default_nettype none

module code_capture (
	input wire logic clk_sys_in, // Shared conversion clock
	input wire logic [conv_pkg::CODE_W-1:0] code_in, // Parallel code
	input wire logic code_update_in, // New code this cycle
	input wire logic code_valid_in, // Code is accurate
	output logic [conv_pkg::CODE_W-1:0] captured_code_out, // Last accepted code
	output int capture_count_out // Accepted codes
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		captured_code_out = 8'h00;
		capture_count_out = 0;
	end

	// Codes after a wake are not trusted until the valid flag returns
	always @(posedge clk_sys_in) begin
		if (code_update_in === 1'b1 && code_valid_in === 1'b1) begin
			captured_code_out <= code_in;
			capture_count_out <= capture_count_out + 1;
		end
	end
endmodule

`default_nettype wire

// [dv/pipelined_sample_output_powerdown_tb.sv]
`default_nettype none

module pipelined_sample_output_powerdown_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int REC = 8;
	logic clk_sys_in, resetn_in, power_down_input_in, clk_run, chk_on;
	logic [11:0] sample_level_in, top_reference_level_in, bottom_reference_level_in;
	logic [7:0] code_out, cap_code_p, prev, held;
	logic code_update_out, code_valid_out, low_power_out;
	logic [31:0] lfsr;
	int mismatches, num_checks, cap_count_p;
	int q[$];
	int m_code, m_state, fill, rc, cap_n, cap_code;
	logic m_upd, m_valid, m_lp;

	converter_top #(.RECOVERY_CYCLES(REC)) i_converter_top (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.sample_level_in(sample_level_in),
		.top_reference_level_in(top_reference_level_in),
		.bottom_reference_level_in(bottom_reference_level_in),
		.power_down_input_in(power_down_input_in),
		.code_out(code_out),
		.code_update_out(code_update_out),
		.code_valid_out(code_valid_out),
		.low_power_out(low_power_out)
	);

	code_capture i_code_capture (
		.clk_sys_in(clk_sys_in),
		.code_in(code_out),
		.code_update_in(code_update_out),
		.code_valid_in(code_valid_out),
		.captured_code_out(cap_code_p),
		.capture_count_out(cap_count_p)
	);

	// Stopping the clock is done by gating this toggle
	always #2 clk_sys_in = clk_run ? ~clk_sys_in : clk_sys_in;

	////////////////////////////////////////////////////////////////
	function automatic int quant(input int lvl, input int bot, input int top);
		if (lvl < bot) return 0;
		if (lvl > top) return 8'hFF;
		if (top == bot) return 0;
		return (lvl - bot) * 8'hFF / (top - bot);
	endfunction

	always @(posedge clk_sys_in) begin
		if (m_upd && m_valid) begin
			cap_n++;
			cap_code = m_code;
		end
		if (resetn_in !== 1'b1) begin
			q = '{0, 0, 0, 0, 0, 0};
			m_code = 0;
			m_upd = 0;
			m_valid = 0;
			m_lp = 0;
			fill = 0;
			rc = 0;
			m_state = 0;
		end else begin
			m_lp = power_down_input_in;
			if (power_down_input_in) begin
				m_upd = 0;
				m_state = 1;
			end else begin
				m_code = q.pop_back();
				q.push_front(quant(sample_level_in, bottom_reference_level_in, top_reference_level_in));
				m_upd = 1;
				if (fill < 6) fill++;
				if (m_state == 1) begin
					m_state = 2;
					rc = 0;
				end else if (m_state == 2) begin
					rc++;
					if (rc == REC) m_state = 0;
				end
			end
			m_valid = (m_state == 0) && (fill >= 6);
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	always @(negedge clk_sys_in) begin
		if (chk_on) begin
			check(code_out, 8'(m_code));
			check({7'h00, code_update_out}, {7'h00, m_upd});
			check({7'h00, code_valid_out}, {7'h00, m_valid});
			check({7'h00, low_power_out}, {7'h00, m_lp});
		end
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic end_test(input string name);
		check(cap_code_p, 8'(cap_code));
		check(8'(cap_count_p), 8'(cap_n));
		$display("Test %s done", name);
	endtask

	task automatic wait_valid(input int limit);
		int n;
		n = 0;
		while (code_valid_out !== 1'b1 && n < limit) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		if (code_valid_out !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t ns: valid flag never rose", $time);
			complete_run();
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Random level, with some levels pinned to the reference edges
	task automatic step(input logic pd);
		@(posedge clk_sys_in);
		#1;
		lfsr = lfsr_next(lfsr);
		sample_level_in = lfsr[11:0];
		if (lfsr[14:12] == 3'h0) sample_level_in = bottom_reference_level_in;
		if (lfsr[14:12] == 3'h1) sample_level_in = top_reference_level_in;
		if (lfsr[20:15] == 6'h00) {top_reference_level_in, bottom_reference_level_in} = lfsr[31:8];
		if (lfsr[20:15] == 6'h01) top_reference_level_in = bottom_reference_level_in;
		power_down_input_in = pd;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		clk_run = 1'b1;
		chk_on = 1'b0;
		resetn_in = 1'b0;
		power_down_input_in = 1'b0;
		sample_level_in = 12'h000;
		top_reference_level_in = 12'hC00;
		bottom_reference_level_in = 12'h200;
		lfsr = 32'h000102C4;
		mismatches = 0;
		num_checks = 0;
		cap_n = 0;
		cap_code = 0;
		repeat (20) @(posedge clk_sys_in);
		#1;
		resetn_in = 1'b1;
		chk_on = 1'b1;
		wait_valid(20);
		for (int i = 0; i < 400; i++) step(1'b0);
		end_test("random stream");

		top_reference_level_in = 12'hE00;
		bottom_reference_level_in = 12'h100;
		for (int i = 0; i < 256; i++) begin
			@(posedge clk_sys_in);
			#1;
			if (i > 7) check({7'h00, code_out >= prev}, 8'h01);
			prev = code_out;
			sample_level_in = 12'(i * 16);
		end
		end_test("ramp");

		for (int i = 0; i < 60; i++) step(i inside {[5:14], [20:22], [27:27]});
		for (int i = 0; i < 30; i++) step(1'b0);
		end_test("power down");

		@(posedge clk_sys_in);
		#1;
		held = code_out;
		clk_run = 1'b0;
		#100;
		sample_level_in = ~sample_level_in;
		#100;
		check(code_out, held);
		clk_run = 1'b1;
		for (int i = 0; i < 20; i++) step(1'b0);
		end_test("clock stop");

		step(1'b1);
		resetn_in = 1'b0;
		repeat (3) step(1'b1);
		resetn_in = 1'b1;
		step(1'b0);
		wait_valid(20);
		for (int i = 0; i < 40; i++) step(1'b0);
		end_test("second reset");
		complete_run();
	end
endmodule

`default_nettype wire

// [rtl/code_pipeline.sv]
`default_nettype none

module code_pipeline (
	input wire logic clk_sys_in, // System clock
	input wire logic resetn_in, // Synchronous reset, active low
	conv_code_if.pipe code_if, // Advance and quantised code in
	output logic [conv_pkg::CODE_W-1:0] code_out // Last pipeline stage
);

	logic [conv_pkg::CODE_W-1:0] stage [conv_pkg::PIPE_LATENCY];
	logic [conv_pkg::CODE_W-1:0] feed [conv_pkg::PIPE_LATENCY];
	logic [conv_pkg::CODE_W-1:0] next_stage [conv_pkg::PIPE_LATENCY];

	////////////////////////////////////////////////////////////////////////
	// Every stage moves together, so a stopped clock or a held advance keeps all codes
	genvar i;
	generate
		for (i = 0; i < conv_pkg::PIPE_LATENCY; i++) begin : g_stage
			if (i == 0) begin : g_head
				assign feed[i] = code_if.code;
			end else begin : g_body
				assign feed[i] = stage[i-1];
			end
			assign next_stage[i] = code_if.advance ? feed[i] : stage[i]; // [RULE5] [RULE10]
		end
	endgenerate

	always_ff @(posedge clk_sys_in) begin
		for (int k = 0; k < conv_pkg::PIPE_LATENCY; k++) begin
			if (!resetn_in) begin
				stage[k] <= conv_pkg::CODE_ZERO;
			end else begin
				stage[k] <= next_stage[k];
			end
		end
	end

	assign code_out = stage[conv_pkg::PIPE_LATENCY-1];

	////////////////////////////////////////////////////////////////////////
	property p_shift;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_if.advance |=> code_out == $past(stage[conv_pkg::PIPE_LATENCY-2]);
	endproperty
	a_shift: assert property (p_shift) else $error("pipeline did not shift"); // [RULE11]

endmodule

`default_nettype wire

// [rtl/conv_code_if.sv]
`default_nettype none

interface conv_code_if;
	logic advance;
	logic [conv_pkg::CODE_W-1:0] code;

	modport quant (
		input advance,
		output code
	);

	modport pipe (
		input advance,
		input code
	);
endinterface

`default_nettype wire

// [rtl/conv_pkg.sv]
`default_nettype none

package conv_pkg;

	localparam int CODE_W = 8;
	localparam int LEVEL_W = 12;
	localparam int SCALE_W = LEVEL_W + CODE_W;
	localparam int PIPE_LATENCY = 6;
	localparam int FILL_W = 3;
	localparam logic [FILL_W-1:0] FILL_DONE = FILL_W'(PIPE_LATENCY);

	localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
	localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 12'h000;

	// Clock period in picoseconds and recovery time in microseconds
	localparam int CLK_PERIOD_PS = 4000;
	localparam int RECOVERY_TIME_US = 1000;
	// A least time, so it rounds up
	localparam int RECOVERY_CYCLES = (RECOVERY_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 18;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_DOWN = 2'b01,
		PWR_RECOVER = 2'b10
	} pwr_state_t;

	// Straight binary code, clamped outside the reference span
	function automatic logic [CODE_W-1:0] quantise(input logic [LEVEL_W-1:0] level,
		input logic [LEVEL_W-1:0] bottom, input logic [LEVEL_W-1:0] top);
		logic [LEVEL_W-1:0] span;
		logic [LEVEL_W-1:0] diff;
		logic [SCALE_W-1:0] scaled;
		span = top - bottom;
		diff = level - bottom;
		scaled = (SCALE_W'(diff) * SCALE_W'(CODE_FULL)) / SCALE_W'(span);
		if (level < bottom) begin
			quantise = CODE_ZERO;
		end else if (level > top) begin
			quantise = CODE_FULL;
		end else if (span == LEVEL_RESET) begin
			quantise = CODE_ZERO;
		end else begin
			quantise = scaled[CODE_W-1:0];
		end
	endfunction

endpackage

`default_nettype wire

// [rtl/converter_top.sv]
// Overview of operation
// RULE1: Quantise in-range sample to eight-bit code.
// RULE2: Below bottom reference gives all zeros.
// RULE3: Above top reference gives all ones.
// RULE4: Sample taken on every rising clock edge.
// RULE5: Code appears six clocks after sampling.
// RULE6: Converts continuously, no start command needed.
// RULE7: Power-down low means normal conversion.
// RULE8: Power-down high freezes outputs, low power.
// RULE9: Ignore codes for one millisecond after wake.
// RULE10: Stopped clock keeps last code driven.
// RULE11: Fresh code every clock once pipeline full.
// RULE12: Straight binary, monotonic from bottom to top.
`default_nettype none

module converter_top #(
	parameter int unsigned RECOVERY_CYCLES = conv_pkg::RECOVERY_CYCLES
) (
	input wire logic clk_sys_in, // Conversion clock
	input wire logic resetn_in, // Synchronous reset, active low
	input wire logic [conv_pkg::LEVEL_W-1:0] sample_level_in, // Input level
	input wire logic [conv_pkg::LEVEL_W-1:0] top_reference_level_in, // Top of range
	input wire logic [conv_pkg::LEVEL_W-1:0] bottom_reference_level_in, // Bottom of range
	input wire logic power_down_input_in, // High stops conversion
	output logic [conv_pkg::CODE_W-1:0] code_out, // Parallel output code
	output logic code_update_out, // Pulse: new code this cycle
	output logic code_valid_out, // Level: code is accurate
	output logic low_power_out // Level: in low-power state
);

	conv_code_if code_if ();

	logic advance;
	conv_pkg::pwr_state_t pwr_state;
	conv_pkg::pwr_state_t next_pwr_state;
	logic [conv_pkg::CNT_W-1:0] recover_count;
	logic [conv_pkg::CNT_W-1:0] next_recover_count;
	logic [conv_pkg::FILL_W-1:0] fill_count;
	logic [conv_pkg::FILL_W-1:0] next_fill_count;
	logic code_update;
	logic next_code_update;
	logic code_valid;
	logic next_code_valid;
	logic low_power;
	logic next_low_power;
	logic recover_last;

	////////////////////////////////////////////////////////////////////////
	// Free-running conversion: only power-down or reset stops the pipeline
	assign advance = resetn_in && !power_down_input_in; // [RULE6] [RULE7] [RULE8]
	assign code_if.advance = advance;

	sample_quantiser u_quantiser (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.level_in(sample_level_in),
		.bottom_in(bottom_reference_level_in),
		.top_in(top_reference_level_in),
		.code_if(code_if)
	);

	code_pipeline u_pipeline (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.code_if(code_if),
		.code_out(code_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Power state: down while the input is high, then a recovery wait.
	// Recovery counter is wide enough for the full wait; a shorter parameter
	// lets simulation skip most of it.
	assign recover_last = (recover_count == conv_pkg::CNT_W'(RECOVERY_CYCLES - 1));

	always_comb begin
		next_pwr_state = pwr_state;
		next_recover_count = recover_count;
		case (pwr_state)
			conv_pkg::PWR_ACTIVE: begin
				if (power_down_input_in) begin // [RULE8]
					next_pwr_state = conv_pkg::PWR_DOWN;
				end
			end
			conv_pkg::PWR_DOWN: begin
				if (!power_down_input_in) begin // [RULE9]
					next_pwr_state = conv_pkg::PWR_RECOVER;
					next_recover_count = '0;
				end
			end
			conv_pkg::PWR_RECOVER: begin
				if (power_down_input_in) begin
					next_pwr_state = conv_pkg::PWR_DOWN;
				end else if (recover_last) begin // [RULE9]
					next_pwr_state = conv_pkg::PWR_ACTIVE;
				end else begin
					next_recover_count = recover_count + 1'b1;
				end
			end
			default: begin
				next_pwr_state = conv_pkg::PWR_ACTIVE;
				next_recover_count = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			pwr_state <= conv_pkg::PWR_ACTIVE;
			recover_count <= '0;
		end else begin
			pwr_state <= next_pwr_state;
			recover_count <= next_recover_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fill tracking and output flags.
	// The pipeline keeps its contents across power-down, so fill is only
	// rebuilt after reset; accuracy after wake is the recovery wait's job.
	always_comb begin
		next_fill_count = fill_count;
		if (advance && (fill_count != conv_pkg::FILL_DONE)) begin // [RULE11]
			next_fill_count = fill_count + 1'b1;
		end
		next_code_update = advance; // [RULE11]
		next_low_power = power_down_input_in; // [RULE8]
		next_code_valid = (next_pwr_state == conv_pkg::PWR_ACTIVE) && !power_down_input_in
			&& (next_fill_count == conv_pkg::FILL_DONE); // [RULE9]
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			fill_count <= '0;
			code_update <= 1'b0;
			code_valid <= 1'b0;
			low_power <= 1'b0;
		end else begin
			fill_count <= next_fill_count;
			code_update <= next_code_update;
			code_valid <= next_code_valid;
			low_power <= next_low_power;
		end
	end

	assign code_update_out = code_update;
	assign code_valid_out = code_valid;
	assign low_power_out = low_power;

	////////////////////////////////////////////////////////////////////////
	// Code path checks
	property p_latency;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		advance [*7] |=> code_out == conv_pkg::quantise($past(sample_level_in, 7),
			$past(bottom_reference_level_in, 7), $past(top_reference_level_in, 7));
	endproperty
	a_latency: assert property (p_latency) else $error("code not six clocks after its sample"); // [RULE5]

	property p_in_range;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(advance && (sample_level_in == top_reference_level_in)
			&& (top_reference_level_in > bottom_reference_level_in)) ##1 advance [*6]
		|=> code_out == conv_pkg::CODE_FULL;
	endproperty
	a_in_range: assert property (p_in_range) else $error("top of range not full code"); // [RULE1]

	property p_under;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(advance && (sample_level_in < bottom_reference_level_in)) ##1 advance [*6]
		|=> code_out == conv_pkg::CODE_ZERO;
	endproperty
	a_under: assert property (p_under) else $error("underrange not all zeros"); // [RULE2]

	property p_over;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(advance && (sample_level_in > top_reference_level_in)) ##1 advance [*6]
		|=> code_out == conv_pkg::CODE_FULL;
	endproperty
	a_over: assert property (p_over) else $error("overrange not all ones"); // [RULE3]

	property p_active;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!power_down_input_in |=> code_update_out && !low_power_out;
	endproperty
	a_active: assert property (p_active) else $error("not converting with power-down low"); // [RULE7]

	// The update flag lags by one edge, so the two edges ending the run are checked
	property p_continuous;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!power_down_input_in [*2] |-> code_update_out [*2];
	endproperty
	a_continuous: assert property (p_continuous) else $error("conversion paused without cause"); // [RULE6]

	property p_fresh;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(fill_count == conv_pkg::FILL_DONE) && advance |=> code_update_out ##0 $past(advance);
	endproperty
	a_fresh: assert property (p_fresh) else $error("no fresh code with full pipeline"); // [RULE11]

	////////////////////////////////////////////////////////////////////////
	// Power-down and recovery checks
	property p_frozen;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		power_down_input_in ##1 power_down_input_in |=> $stable(code_out) && low_power_out;
	endproperty
	a_frozen: assert property (p_frozen) else $error("output moved during power-down"); // [RULE8] [RULE10]

	property p_down_invalid;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		power_down_input_in |=> !code_valid_out && !code_update_out;
	endproperty
	a_down_invalid: assert property (p_down_invalid) else $error("valid during power-down"); // [RULE8]

	// Right after reset the state is active, so a fall there starts no wait
	property p_wake;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$fell(power_down_input_in) && (pwr_state == conv_pkg::PWR_DOWN)
		|=> (pwr_state == conv_pkg::PWR_RECOVER) && (recover_count == '0) && !code_valid_out;
	endproperty
	a_wake: assert property (p_wake) else $error("recovery wait not started on wake"); // [RULE9]

	property p_recover_invalid;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(pwr_state == conv_pkg::PWR_RECOVER) |-> !code_valid_out;
	endproperty
	a_recover_invalid: assert property (p_recover_invalid) else $error("valid during recovery"); // [RULE9]

	property p_recover_end;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(pwr_state == conv_pkg::PWR_RECOVER) && recover_last && !power_down_input_in
		|=> (pwr_state == conv_pkg::PWR_ACTIVE) && (code_valid_out == (fill_count == conv_pkg::FILL_DONE));
	endproperty
	a_recover_end: assert property (p_recover_end) else $error("recovery did not end on count"); // [RULE9]

	property p_count_step;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(pwr_state == conv_pkg::PWR_RECOVER) && !recover_last && !power_down_input_in
		|=> recover_count == $past(recover_count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("recovery counter stalled"); // [RULE9]

	////////////////////////////////////////////////////////////////////////
	// Flag and state checks: the valid flag is local, so these pin down its meaning
	property p_low_power_follows;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		power_down_input_in |=> low_power_out;
	endproperty
	a_low_power_follows: assert property (p_low_power_follows) else $error("low-power flag missing"); // [RULE8]

	property p_hold_down;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		power_down_input_in |=> $stable(code_out);
	endproperty
	a_hold_down: assert property (p_hold_down) else $error("code moved on a power-down edge"); // [RULE8]

	property p_stay_down;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(pwr_state == conv_pkg::PWR_DOWN) && power_down_input_in |=> pwr_state == conv_pkg::PWR_DOWN;
	endproperty
	a_stay_down: assert property (p_stay_down) else $error("left power-down while input high"); // [RULE8]

	property p_recover_restart;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(pwr_state == conv_pkg::PWR_RECOVER) && power_down_input_in
		|=> (pwr_state == conv_pkg::PWR_DOWN) && !code_valid_out;
	endproperty
	a_recover_restart: assert property (p_recover_restart) else $error("recovery not cut by power-down"); // [RULE9]

	property p_low_power_exit;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$fell(power_down_input_in) |=> !low_power_out && code_update_out;
	endproperty
	a_low_power_exit: assert property (p_low_power_exit) else $error("conversion not resumed on wake"); // [RULE7]

	property p_valid_filled;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_valid_out |-> fill_count == conv_pkg::FILL_DONE;
	endproperty
	a_valid_filled: assert property (p_valid_filled) else $error("valid before pipeline filled"); // [RULE11]

	property p_valid_active;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_valid_out |-> (pwr_state == conv_pkg::PWR_ACTIVE) && !low_power_out;
	endproperty
	a_valid_active: assert property (p_valid_active) else $error("valid outside active state"); // [RULE9]

	property p_valid_holds;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_valid_out && !power_down_input_in |=> code_valid_out;
	endproperty
	a_valid_holds: assert property (p_valid_holds) else $error("valid dropped while converting"); // [RULE11]

	property p_fill_step;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		advance && (fill_count != conv_pkg::FILL_DONE) |=> fill_count == $past(fill_count) + 1'b1;
	endproperty
	a_fill_step: assert property (p_fill_step) else $error("fill count did not step"); // [RULE11]

	property p_update_cause;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_update_out |-> $past(advance);
	endproperty
	a_update_cause: assert property (p_update_cause) else $error("update without an advancing edge"); // [RULE6]

endmodule

`default_nettype wire

// [rtl/sample_quantiser.sv]
`default_nettype none

module sample_quantiser (
	input wire logic clk_sys_in, // System clock
	input wire logic resetn_in, // Synchronous reset, active low
	input wire logic [conv_pkg::LEVEL_W-1:0] level_in, // Input level to sample
	input wire logic [conv_pkg::LEVEL_W-1:0] bottom_in, // Bottom reference level
	input wire logic [conv_pkg::LEVEL_W-1:0] top_in, // Top reference level
	conv_code_if.quant code_if // Advance in, quantised code out
);

	logic [conv_pkg::LEVEL_W-1:0] level;
	logic [conv_pkg::LEVEL_W-1:0] bottom;
	logic [conv_pkg::LEVEL_W-1:0] top;
	logic [conv_pkg::LEVEL_W-1:0] next_level;
	logic [conv_pkg::LEVEL_W-1:0] next_bottom;
	logic [conv_pkg::LEVEL_W-1:0] next_top;

	////////////////////////////////////////////////////////////////////////
	// Track and hold: one sample per advancing edge
	always_comb begin
		next_level = level;
		next_bottom = bottom;
		next_top = top;
		if (code_if.advance) begin // [RULE4]
			next_level = level_in;
			next_bottom = bottom_in;
			next_top = top_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			level <= conv_pkg::LEVEL_RESET;
			bottom <= conv_pkg::LEVEL_RESET;
			top <= conv_pkg::LEVEL_RESET;
		end else begin
			level <= next_level;
			bottom <= next_bottom;
			top <= next_top;
		end
	end

	// Clamped straight binary conversion of the held sample
	assign code_if.code = conv_pkg::quantise(level, bottom, top); // [RULE1] [RULE2] [RULE3] [RULE12]

	////////////////////////////////////////////////////////////////////////
	property p_sample_taken;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		code_if.advance |=> (level == $past(level_in)) && (top == $past(top_in));
	endproperty
	a_sample_taken: assert property (p_sample_taken) else $error("sample not taken on advancing edge"); // [RULE4]

	property p_monotonic;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		($stable(bottom) && $stable(top) && (level > $past(level))) |-> (code_if.code >= $past(code_if.code));
	endproperty
	a_monotonic: assert property (p_monotonic) else $error("code fell while level rose"); // [RULE12]

endmodule

`default_nettype wire
